/* dv/asr_link_checker.sv */
/*
 * Assertions on the link between audio controller and receiver.
 * Assumes it sits beside the link interface and shares clk.
 */
`timescale 1ns/1ps
`include "asr_consts.svh"

module asr_link_checker
	import asr_pkg::*;
(
	// Clock and reset
	input wire logic        clk,
	input wire logic        sys_rst,
	// Serial link
	input wire logic        bit_clock,
	input wire logic        frame_sync,
	input wire logic        serial_data,
	// Register port
	input wire logic        reg_wr,
	input wire logic [15:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	// Received samples
	input wire logic [2:0]  sample_chan,
	input wire logic        sample_valid
);
	logic       bclk_q;
	logic [3:0] since_q;
	logic       mapped;

	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	assign mapped = reg_addr inside {`ASR_REG_MC, `ASR_REG_FA,
		`ASR_REG_FB, `ASR_REG_DL, `ASR_REG_DR};

	// Clocks since the raw bit clock last rose
	always_ff @(posedge clk)
	begin
		bclk_q <= bit_clock;
		if (sys_rst)
			since_q <= 4'hf;
		else if (bit_clock && !bclk_q)
			since_q <= 4'h0;
		else if (since_q != 4'hf)
			since_q <= since_q + 4'h1;
	end

	////////////////////////////////////////
	chk_bclk_high: assert property (
		$rose(bit_clock) |-> bit_clock [*4])
		else $error("bit clock high phase too short");
	chk_bclk_low: assert property (
		$fell(bit_clock) |-> !bit_clock [*4])
		else $error("bit clock low phase too short");
	chk_fs_edge: assert property (
		$changed(frame_sync) |-> !bit_clock)
		else $error("frame sync moved while bit clock high");
	chk_data_edge: assert property (
		$changed(serial_data) |-> !bit_clock)
		else $error("data moved while bit clock high");
	chk_reg_readback: assert property (
		reg_wr && mapped ##1 $stable(reg_addr)
		|=> reg_rdata == $past(reg_wdata, 2))
		else $error("register readback differs from write");
	chk_reg_unmapped: assert property (
		reg_wr && !mapped && reg_addr != 16'h0000 ##1 $stable(reg_addr)
		|=> reg_rdata == 16'h0000)
		else $error("unmapped register reads nonzero");
	chk_valid_timing: assert property (
		sample_valid |-> since_q inside {[4'h2:4'h5]})
		else $error("sample not tied to a bit clock rise");
	chk_valid_pair: assert property (
		sample_valid && $past(sample_valid)
		|-> sample_chan == 3'h1 && $past(sample_chan) == 3'h0)
		else $error("back to back samples not channel 0 then 1");
	chk_valid_short: assert property (
		sample_valid [*2] |=> !sample_valid)
		else $error("sample valid too long");

	cover property (sample_valid && sample_chan == 3'h7);
	cover property (sample_valid [*2]);
	cover property (reg_wr && !mapped);
endmodule // asr_link_checker

/* dv/audio_serial_slave_receiver_tb.sv */
/*
 * Testbench: controller end facing receiver end over the link.
 * Assumes both ends and the checker compile beside it.
 */
`timescale 1ns/1ps
`include "asr_consts.svh"

module audio_serial_slave_receiver_tb
	import asr_pkg::*;
;
	localparam logic [31:0] TX = 32'h9e3c_5a71;
	typedef struct packed {
		logic [7:0]  fa;
		logic [1:0]  mcb;
		logic        ts;
		logic [9:0]  dl;
		logic [9:0]  dr;
		logic [1:0]  ctrl;
		logic [31:0] frame;
		logic [5:0]  w;
	} asr_row_s;

	logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, sample_data, rd, expd, e;
	logic [2:0]  sample_chan;
	logic        sample_valid, er, mon;
	logic [7:0]  seen;
	int          error_cnt = 0;
	int          tests_run = 0;
	asr_row_s    rows [13] = '{
		'{8'h00,2'h0,1'h0,10'h000,10'h000,2'h1,32'h0050_1020,6'h10},
		'{8'h09,2'h0,1'h0,10'h000,10'h000,2'h1,32'h0058_0020,6'h18},
		'{8'h0e,2'h0,1'h0,10'h000,10'h000,2'h1,32'h0040_0128,6'h20},
		'{8'h05,2'h0,1'h0,10'h000,10'h000,2'h1,32'h0054_0020,6'h14},
		'{8'h11,2'h0,1'h0,10'h000,10'h000,2'h1,32'h0048_0010,6'h08},
		'{8'h81,2'h0,1'h0,10'h000,10'h000,2'h1,32'h0048_0010,6'h08},
		'{8'h01,2'h2,1'h0,10'h000,10'h000,2'h1,32'h0110_0040,6'h10},
		'{8'h02,2'h2,1'h0,10'h000,10'h000,2'h1,32'h0110_0148,6'h10},
		'{8'h03,2'h0,1'h0,10'h000,10'h000,2'h3,32'h0210_0148,6'h10},
		'{8'h43,2'h0,1'h0,10'h000,10'h000,2'h3,32'h0210_0048,6'h10},
		'{8'h03,2'h0,1'h1,10'h005,10'h015,2'h3,32'h0090_0518,6'h10},
		'{8'h03,2'h1,1'h0,10'h003,10'h000,2'h3,32'h0210_0348,6'h10},
		'{8'h03,2'h0,1'h1,10'h005,10'h005,2'h3,32'h0050_0518,6'h10}};

	asr_if link ();
	asr_dev_end u_asr_dev_end (.clk(clk), .sys_rst(sys_rst), .link(link),
		.sample_data(sample_data), .sample_chan(sample_chan),
		.sample_valid(sample_valid));
	asr_ctl_end u_asr_ctl_end (.clk(clk), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
	asr_link_checker u_asr_link_checker (.clk(clk), .sys_rst(sys_rst),
		.bit_clock(link.bit_clock), .frame_sync(link.frame_sync),
		.serial_data(link.serial_data), .reg_wr(link.reg_wr),
		.reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata),
		.reg_rdata(link.reg_rdata), .sample_chan(sample_chan),
		.sample_valid(sample_valid));

	initial clk = 1'b0;
	always #25 clk = ~clk;

	////////////////////////////////////////
	task check(input logic [31:0] s, input logic [31:0] x);
		tests_run++;
		if (s !== x)
		begin
			error_cnt++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask

	task give_verdict;
		$display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task dw(input logic [15:0] a, input logic [15:0] d);
		apb(1'b1, `ASR_APB_DCMD, {a, d});
		apb(1'b1, `ASR_APB_DWRITE, 32'h0);
	endtask

	task rr(input logic [15:0] a);
		apb(1'b1, `ASR_APB_DCMD, {a, 16'h0000});
		repeat (3) @(posedge clk);
		apb(1'b0, `ASR_APB_DREAD, 32'h0);
	endtask

	// Configure both ends, skip the first frames, then watch
	task run_case(input asr_row_s r, input logic [31:0] x);
		logic [7:0] m;
		m = (r.mcb != 2'h0 || (r.fa[1:0] == 2'h3 && !r.ts)) ? 8'hff : 8'h03;
		apb(1'b1, `ASR_APB_CTRL, 32'h0);
		dw(`ASR_REG_MC, {r.mcb, 14'h0000});
		dw(`ASR_REG_FA, {8'h00, r.fa});
		dw(`ASR_REG_FB, {5'h00, r.ts, 10'h000});
		dw(`ASR_REG_DL, {6'h00, r.dl});
		dw(`ASR_REG_DR, {6'h00, r.dr});
		apb(1'b1, `ASR_APB_FRAME, r.frame);
		apb(1'b1, `ASR_APB_TXDATA, TX);
		apb(1'b1, `ASR_APB_CTRL, {30'h0, r.ctrl});
		expd = x;
		repeat (1500) @(posedge clk);
		seen <= 8'h00;
		mon  <= 1'b1;
		repeat (2500) @(posedge clk);
		mon <= 1'b0;
		@(posedge clk);
		check({24'h0, seen}, {24'h0, m});
	endtask

	always @(posedge clk)
	begin
		if (mon && sample_valid === 1'b1)
		begin
			check(sample_data, expd);
			seen <= seen | (8'h01 << sample_chan);
		end
	end

	////////////////////////////////////////
	initial
	begin
		{sys_rst, psel, penable, pwrite, paddr, pwdata} = {4'h8, 8'h00, 32'h0};
		{mon, seen, expd} = {1'b0, 8'h00, 32'h0};
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		foreach (rows[i])
		begin
			e = rows[i].w == 6'h20 ? TX : TX & ((32'h1 << rows[i].w) - 32'h1);
			run_case(rows[i], e);
		end
		// Longer word sent than configured
		run_case('{8'h01,2'h0,1'h0,10'h000,10'h000,2'h1,32'h0058_0020,6'h10},
			32'h0000_3c5a);
		dw(`ASR_REG_DL, 16'h03ff);
		rr(`ASR_REG_DL);
		check(rd, 32'h0000_03ff);
		dw(16'h0011, 16'h1234);
		rr(16'h0011);
		check(rd, 32'h0);
		apb(1'b0, 8'h1c, 32'h0);
		check({31'h0, er}, 32'h1);
		// Reset while frames are running
		sys_rst <= 1'b1;
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		rr(`ASR_REG_FA);
		check(rd, 32'h0);
		apb(1'b0, `ASR_APB_STATUS, 32'h0);
		check(rd, 32'h0);
		give_verdict;
	end

	initial
	begin
		repeat (90000) @(posedge clk);
		error_cnt++;
		give_verdict;
	end
endmodule // audio_serial_slave_receiver_tb

/* pkg/asr_consts.svh */
/*
 * Offsets, field positions and timing counts of the serial audio link.
 * Assumes it is included by the package and the two link ends.
 */
`ifndef ASR_CONSTS_SVH
`define ASR_CONSTS_SVH

// Receiver registers (16-bit address, 16-bit data)
`define ASR_REG_MC        16'h000c
`define ASR_REG_FA        16'h000d
`define ASR_REG_FB        16'h000e
`define ASR_REG_DL        16'h000f
`define ASR_REG_DR        16'h0010
`define ASR_REG_RESET     16'h0000
// Receiver field positions
`define ASR_MC_TDM_BIT    15
`define ASR_MC_OFF_BIT    14
`define ASR_FA_WLEN_MSB   4
`define ASR_FA_WLEN_LSB   2
`define ASR_FA_POL_BIT    6
`define ASR_FA_CMP_BIT    7
`define ASR_FB_TS_BIT     10
`define ASR_DLY_MSB       9
// Format codes
`define ASR_FMT_RJ        2'h0
`define ASR_FMT_LJ        2'h1
`define ASR_FMT_I2S       2'h2
// Word length codes
`define ASR_WL_C16        3'h0
`define ASR_WL_C20        3'h1
`define ASR_WL_C24        3'h2
`define ASR_WL_C32        3'h3
`define ASR_WL_C8         3'h4
// Controller APB register offsets
`define ASR_APB_CTRL      8'h00
`define ASR_APB_FRAME     8'h04
`define ASR_APB_TXDATA    8'h08
`define ASR_APB_STATUS    8'h0c
`define ASR_APB_DCMD      8'h10
`define ASR_APB_DWRITE    8'h14
`define ASR_APB_DREAD     8'h18
// Timing
`define ASR_CLK_NS        50
`define ASR_BCLK_NS       400
`define ASR_BCLK_HALF     (`ASR_BCLK_NS / `ASR_CLK_NS / 2)

`endif

/* pkg/asr_if.sv */
/*
 * Link between the audio controller and the audio receiver.
 * Assumes both ends run on the same system clock for the register lines.
 */
`timescale 1ns/1ps

interface asr_if;
	logic        bit_clock;
	logic        frame_sync;
	logic        serial_data;
	logic        reg_wr;
	logic [15:0] reg_addr;
	logic [15:0] reg_wdata;
	logic [15:0] reg_rdata;

	modport dev (
		input  bit_clock, frame_sync, serial_data,
		input  reg_wr, reg_addr, reg_wdata,
		output reg_rdata
	);
	modport ctl (
		output bit_clock, frame_sync, serial_data,
		output reg_wr, reg_addr, reg_wdata,
		input  reg_rdata
	);
endinterface

/* pkg/asr_pkg.sv */
/*
 * Types shared by both ends of the serial audio link.
 * Assumes asr_consts.svh is on the include path.
 */
`include "asr_consts.svh"

package asr_pkg;

	typedef enum logic [3:0] {
		ASR_RJ, ASR_LJ, ASR_I2S, ASR_TDM_LJ, ASR_TDM_I2S,
		ASR_PCM_A, ASR_PCM_B, ASR_PCM_TS, ASR_PCM_OFF
	} asr_mode_e;

	typedef struct packed {
		logic [2:0]  bclk_s;
		logic [1:0]  fs_s;
		logic [1:0]  sd_s;
		logic        fs_prev;
		logic [31:0] sreg;
		logic [10:0] k;
		logic [10:0] tgt;
		logic [10:0] tgt2;
		logic        t2_en;
		logic [3:0]  nleft;
		logic [2:0]  ch;
		logic [2:0]  step;
		logic [15:0] mc;
		logic [15:0] fa;
		logic [15:0] fb;
		logic [15:0] dl;
		logic [15:0] dr;
		logic [15:0] rdata;
		logic        pend;
		logic [31:0] pend_data;
		logic [31:0] out_data;
		logic [2:0]  out_ch;
		logic        out_valid;
	} asr_dev_s;

	typedef struct packed {
		logic [2:0]  div;
		logic        bclk;
		logic        fs;
		logic        sd;
		logic [8:0]  p;
		logic [4:0]  bc;
		logic [3:0]  sc;
		logic        act;
		logic [31:0] ctrl;
		logic [31:0] frame;
		logic [31:0] tx;
		logic [31:0] dcmd;
		logic        dwr;
		logic [15:0] drd;
		logic [15:0] fcount;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} asr_host_s;

endpackage

/* verilog/asr_ctl_end.sv */
/*
 * Audio controller end: makes bit clock and frame sync, shifts out a
 * sample word, and relays register accesses to the receiver; APB slave.
 * Assumes the receiver shares clk for the register lines.
 */
`timescale 1ns/1ps
`include "asr_consts.svh"

module asr_ctl_end
	import asr_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Link
	asr_if.ctl               link
);

	asr_host_s q;
	asr_host_s d;

	always_comb
	begin
		logic       setup;
		logic       fall;
		logic [8:0] len;
		logic [8:0] pn;
		logic [7:0] lead;
		logic [4:0] wm1;
		logic [3:0] ns;
		setup = psel & ~penable;
		len   = q.ctrl[1] ? {q.frame[7:0], 1'b0} : {1'b0, q.frame[7:0]};
		lead  = q.frame[15:8];
		wm1   = q.frame[20:16] - 5'h01;
		ns    = q.frame[25:22];
		pn    = 9'h000;
		fall  = 1'b0;
		d = q;
		d.dwr    = 1'b0;
		d.pready = 1'b0;
		d.drd    = link.reg_rdata;

		// APB: answer in the first access cycle
		if (setup)
		begin
			d.pready  = 1'b1;
			d.pslverr = 1'b0;
			d.prdata  = 32'h00000000;
			if (paddr == `ASR_APB_CTRL)
				d.prdata = q.ctrl;
			else if (paddr == `ASR_APB_FRAME)
				d.prdata = q.frame;
			else if (paddr == `ASR_APB_TXDATA)
				d.prdata = q.tx;
			else if (paddr == `ASR_APB_STATUS)
				d.prdata = {15'h0000, q.ctrl[0], q.fcount};
			else if (paddr == `ASR_APB_DCMD)
				d.prdata = q.dcmd;
			else if (paddr == `ASR_APB_DREAD)
				d.prdata = {16'h0000, q.drd};
			else if (paddr != `ASR_APB_DWRITE)
				d.pslverr = 1'b1;
		end
		if (psel && penable && q.pready && pwrite)
		begin
			if (paddr == `ASR_APB_CTRL)
				d.ctrl = pwdata;
			else if (paddr == `ASR_APB_FRAME)
				d.frame = pwdata;
			else if (paddr == `ASR_APB_TXDATA)
				d.tx = pwdata;
			else if (paddr == `ASR_APB_DCMD)
				d.dcmd = pwdata;
			else if (paddr == `ASR_APB_DWRITE)
				d.dwr = 1'b1;
		end

		////////////////////////////////////////////////////////////////////
		// Bit clock divider; link lines change on the falling edge
		// Stop waits for the low phase: no short high pulse
		if (!q.ctrl[0] && !q.bclk)
		begin
			d.div  = 3'h0;
			d.bclk = 1'b0;
			d.p    = 9'h1ff;
			d.act  = 1'b0;
			d.sd   = 1'b0;
		end
		else if (q.div == 3'(`ASR_BCLK_HALF - 1))
		begin
			d.div  = 3'h0;
			d.bclk = ~q.bclk;
			fall   = q.bclk;
		end
		else
			d.div = q.div + 3'h1;

		if (fall)
		begin
			pn  = (q.p >= len - 9'h001) ? 9'h000 : q.p + 9'h001;
			d.p = pn;
			if (pn == 9'h000)
			begin
				d.fs     = q.ctrl[1] ? 1'b1 : ~q.fs;
				d.fcount = q.fcount + 16'h0001;
			end
			else if (q.ctrl[1])
				d.fs = 1'b0;
			if (pn == {1'b0, lead} && ns != 4'h0)
			begin
				d.act = 1'b1;
				d.bc  = wm1;
				d.sc  = 4'h0;
			end
			else if (q.act && q.bc == 5'h00)
			begin
				d.bc = wm1;
				d.sc = q.sc + 4'h1;
				if (q.sc == ns - 4'h1)
					d.act = 1'b0;
			end
			else if (q.act)
				d.bc = q.bc - 5'h01;
			d.sd = d.act ? q.tx[d.bc] : 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			q <= '0;
		else
			q <= d;
	end

	assign prdata           = q.prdata;
	assign pready           = q.pready;
	assign pslverr          = q.pslverr;
	assign link.bit_clock   = q.bclk;
	assign link.frame_sync  = q.fs;
	assign link.serial_data = q.sd;
	assign link.reg_wr      = q.dwr;
	assign link.reg_addr    = q.dcmd[31:16];
	assign link.reg_wdata   = q.dcmd[15:0];

endmodule // asr_ctl_end

/* verilog/asr_dev_end.sv */
/*
 * Slave serial audio receiver: nine framing modes, up to eight channels.
 * Assumes bit clock and frame sync come from the controller, asynchronous
 * to clk and slower than clk / 8 per half period.
 */
`timescale 1ns/1ps
`include "asr_consts.svh"
// Behaviour
// - Controller makes bit clock and frame sync
// - Data sampled on bit clock rising edge
// - Word lengths 8/16/20/24/32 from word length field
// - Companding bit forces 8-bit words
// - Format field: 00 RJ, 01 LJ, 10 I2S
// - TDM and PCM carry up to eight channels
// - Software sets TDM enable for TDM framing
// - RJ: LSB just before sync edge
// - LJ: MSB on first edge after sync edge
// - I2S: MSB on second edge, left low
// - TDM LJ: odd channels low, even high
// - TDM I2S: even channels low, odd high
// - PCM A: MSB second edge, back to back
// - PCM B: MSB first edge, back to back
// - No delay enabled: capture right after sync
// - Time slot: left/right delays from registers
// - Software sets slot enable for delays
// - Software sets offset enable for offset mode
// - Offset: channel 0 at left delay, chained
// - Delays allow bus sharing and slot reuse
// - Registers 16-bit address and data
module asr_dev_end
	import asr_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// Link
	asr_if.dev               link,
	// Received samples
	output logic [31:0]      sample_data,
	output logic [2:0]       sample_chan,
	output logic             sample_valid
);

	////////////////////////////////////////////////////////////////////////
	function automatic logic [5:0] word_len(input logic [15:0] fa);
		logic [5:0] w;
		w = 6'd16;
		if (fa[`ASR_FA_CMP_BIT])
			w = 6'd8;
		else
		begin
			case (fa[`ASR_FA_WLEN_MSB:`ASR_FA_WLEN_LSB])
				`ASR_WL_C20: w = 6'd20;
				`ASR_WL_C24: w = 6'd24;
				`ASR_WL_C32: w = 6'd32;
				`ASR_WL_C8:  w = 6'd8;
				default:     w = 6'd16;
			endcase
		end
		return w;
	endfunction

	function automatic asr_mode_e decode_mode(input logic [15:0] mc,
		input logic [15:0] fa, input logic [15:0] fb);
		asr_mode_e m;
		m = ASR_RJ;
		if (mc[`ASR_MC_OFF_BIT])
			m = ASR_PCM_OFF;
		else if (fa[1:0] == `ASR_FMT_RJ)
			m = ASR_RJ;
		else if (fa[1:0] == `ASR_FMT_LJ)
			m = mc[`ASR_MC_TDM_BIT] ? ASR_TDM_LJ : ASR_LJ;
		else if (fa[1:0] == `ASR_FMT_I2S)
			m = mc[`ASR_MC_TDM_BIT] ? ASR_TDM_I2S : ASR_I2S;
		else if (fb[`ASR_FB_TS_BIT])
			m = ASR_PCM_TS;
		else
			m = fa[`ASR_FA_POL_BIT] ? ASR_PCM_B : ASR_PCM_A;
		return m;
	endfunction

	////////////////////////////////////////////////////////////////////////
	asr_dev_s q;
	asr_dev_s d;

	always_comb
	begin
		asr_mode_e   mode;
		logic [5:0]  wl;
		logic [31:0] mask;
		logic        edge_r;
		logic        fs_now;
		logic        trans;
		logic        fstart;
		logic [31:0] nsreg;
		logic [10:0] kk;
		logic [10:0] start;
		logic        hit1;
		mode   = decode_mode(q.mc, q.fa, q.fb);
		wl     = word_len(q.fa);
		mask   = 32'hffffffff >> (6'd32 - wl);
		edge_r = q.bclk_s[1] & ~q.bclk_s[2];
		fs_now = q.fs_s[1];
		trans  = fs_now != q.fs_prev;
		fstart = 1'b0;
		nsreg  = {q.sreg[30:0], q.sd_s[1]};
		kk     = 11'h000;
		start  = 11'h000;
		hit1   = 1'b0;
		d = q;
		d.out_valid = 1'b0;
		// Two-stage synchronisers on the link pins
		d.bclk_s = {q.bclk_s[1:0], link.bit_clock};
		d.fs_s   = {q.fs_s[0], link.frame_sync};
		d.sd_s   = {q.sd_s[0], link.serial_data};

		// Register port
		if (link.reg_wr)
		begin
			if (link.reg_addr == `ASR_REG_MC)
				d.mc = link.reg_wdata;
			else if (link.reg_addr == `ASR_REG_FA)
				d.fa = link.reg_wdata;
			else if (link.reg_addr == `ASR_REG_FB)
				d.fb = link.reg_wdata;
			else if (link.reg_addr == `ASR_REG_DL)
				d.dl = link.reg_wdata;
			else if (link.reg_addr == `ASR_REG_DR)
				d.dr = link.reg_wdata;
		end
		if (link.reg_addr == `ASR_REG_MC)
			d.rdata = q.mc;
		else if (link.reg_addr == `ASR_REG_FA)
			d.rdata = q.fa;
		else if (link.reg_addr == `ASR_REG_FB)
			d.rdata = q.fb;
		else if (link.reg_addr == `ASR_REG_DL)
			d.rdata = q.dl;
		else if (link.reg_addr == `ASR_REG_DR)
			d.rdata = q.dr;
		else
			d.rdata = 16'h0000;

		// Second channel of a shared time slot
		if (q.pend)
		begin
			d.pend      = 1'b0;
			d.out_valid = 1'b1;
			d.out_ch    = 3'h1;
			d.out_data  = q.pend_data;
		end

		////////////////////////////////////////////////////////////////////
		if (edge_r)
		begin
			d.sreg    = nsreg;
			d.fs_prev = fs_now;
			if (mode >= ASR_PCM_A)
				fstart = fs_now & ~q.fs_prev;
			else
				fstart = trans;
			if (fstart)
				kk = 11'h000;
			else if (q.k != 11'h7ff)
				kk = q.k + 11'h001;
			else
				kk = q.k;
			d.k = kk;

			if (mode == ASR_RJ && trans)
			begin
				d.out_valid = 1'b1;
				d.out_ch    = q.fs_prev ? 3'h0 : 3'h1;
				d.out_data  = q.sreg & mask;
			end

			if (fstart)
			begin
				d.t2_en = 1'b0;
				d.nleft = 4'h1;
				d.step  = 3'h1;
				d.ch    = 3'h0;
				case (mode)
					ASR_RJ:
						d.nleft = 4'h0;
					ASR_LJ:
						d.ch = fs_now ? 3'h0 : 3'h1;
					ASR_I2S:
					begin
						start = 11'h001;
						d.ch  = fs_now ? 3'h1 : 3'h0;
					end
					ASR_TDM_LJ:
					begin
						d.ch    = fs_now ? 3'h0 : 3'h1;
						d.nleft = 4'h4;
						d.step  = 3'h2;
					end
					ASR_TDM_I2S:
					begin
						start   = 11'h001;
						d.ch    = fs_now ? 3'h1 : 3'h0;
						d.nleft = 4'h4;
						d.step  = 3'h2;
					end
					ASR_PCM_A:
					begin
						start   = 11'h001;
						d.nleft = 4'h8;
					end
					ASR_PCM_B:
						d.nleft = 4'h8;
					ASR_PCM_TS:
					begin
						start  = {1'b0, q.dl[`ASR_DLY_MSB:0]};
						d.tgt2 = {1'b0, q.dr[`ASR_DLY_MSB:0]} +
							{5'h00, wl} - 11'h001;
						d.t2_en = 1'b1;
					end
					default:
					begin
						start   = {1'b0, q.dl[`ASR_DLY_MSB:0]};
						d.nleft = 4'h8;
					end
				endcase
				d.tgt = start + {5'h00, wl} - 11'h001;
			end
			else
			begin
				if (q.nleft != 4'h0 && kk == q.tgt)
				begin
					hit1        = 1'b1;
					d.out_valid = 1'b1;
					d.out_ch    = q.ch;
					d.out_data  = nsreg & mask;
					d.tgt       = q.tgt + {5'h00, wl};
					d.ch        = q.ch + q.step;
					d.nleft     = q.nleft - 4'h1;
				end
				if (q.t2_en && kk == q.tgt2)
				begin
					d.t2_en = 1'b0;
					if (hit1)
					begin
						d.pend      = 1'b1;
						d.pend_data = nsreg & mask;
					end
					else
					begin
						d.out_valid = 1'b1;
						d.out_ch    = 3'h1;
						d.out_data  = nsreg & mask;
					end
				end
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			q <= '0;
		else
			q <= d;
	end

	assign sample_data    = q.out_data;
	assign sample_chan    = q.out_ch;
	assign sample_valid   = q.out_valid;
	assign link.reg_rdata = q.rdata;

endmodule // asr_dev_end
